// ===== fraops_adder.sv
// Eight-bit adder giving sum, carry out and nibble carry
module fraops_adder (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output logic      [7:0] sum,
  output logic            carry,
  output logic            half_carry
);
  logic [4:0] low;
  logic [8:0] full;

  always_comb begin
    low        = {1'h0, a[3:0]} + {1'h0, b[3:0]};
    full       = {1'h0, a} + {1'h0, b};
    sum        = full[7:0];
    carry      = full[8];
    half_carry = low[4];
  end
endmodule : fraops_adder

// ===== fraops_core.sv
// Execute stage for add, AND and bit-clear on the file registers
`include "fraops_defines.svh"

// Contract
// - Add accumulator and file in one cycle; update carry, half-carry, zero.
// - Destination bit 0: result goes to accumulator, file untouched.
// - Destination bit 1: result goes back to file, accumulator untouched.
// - AND accumulator with file; update only zero flag.
// - Port register operands use pin levels, not output latches.
// - Writing timer count register also clears prescaler when assigned.
module fraops_core (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire fraops_pkg::fraops_instr_t instr,
  input  wire logic [7:0]            file_rd_data,
  input  wire logic                  file_is_port,
  input  wire logic [7:0]            port_pins,
  input  wire logic                  file_is_timer,
  input  wire logic                  prescaler_on_timer,
  output logic [6:0]                 file_rd_addr,
  output fraops_pkg::fraops_fwr_t    file_wr,
  output logic [7:0]                 acc,
  output fraops_pkg::fraops_flags_t  flags,
  output logic                       prescaler_clr
);
  import fraops_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Everything the slice remembers sits in one record, registered in one place
  typedef struct packed {
    logic [7:0]    acc;
    fraops_flags_t flags;
    fraops_fwr_t   fwr;
    logic          pclr;
  } fraops_state_t;

  fraops_state_t st;
  fraops_state_t next_st;

  // ---------------------------------------------------------------
  // Decoded fields
  // ---------------------------------------------------------------
  logic [1:0] cls;
  logic [3:0] op;
  logic [1:0] bop;
  logic       dest;
  logic [2:0] bit_idx;
  logic [6:0] faddr;
  logic       is_add;
  logic       is_and;
  logic       is_bclr;
  logic       is_byte;

  // ---------------------------------------------------------------
  // Datapath nets
  // ---------------------------------------------------------------
  logic [7:0]    operand;
  logic [7:0]    sum;
  logic          sum_c;
  logic          sum_dc;
  logic [7:0]    and_val;
  logic [7:0]    bit_mask;
  logic [7:0]    clr_val;
  logic [7:0]    result;
  logic          result_zero;
  fraops_flags_t new_flags;
  logic          to_acc;
  logic          to_file;
  logic          hits_timer;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Unknown opcodes and idle cycles decode to nothing and change no state
  always_comb begin
    cls     = instr.word[13:12];
    op      = instr.word[11:8];
    bop     = instr.word[11:10];
    dest    = instr.word[7];
    bit_idx = instr.word[9:7];
    faddr   = instr.word[6:0];
    is_add  = 1'h0;
    is_and  = 1'h0;
    is_bclr = 1'h0;
    case (cls)
      `FRAOPS_CLS_BYTE: begin
        is_add = instr.valid && op == `FRAOPS_OP_ADD;
        is_and = instr.valid && op == `FRAOPS_OP_AND;
      end
      `FRAOPS_CLS_BIT: begin
        is_bclr = instr.valid && bop == `FRAOPS_BOP_CLR;
      end
      default: begin
        is_add  = 1'h0;
        is_and  = 1'h0;
        is_bclr = 1'h0;
      end
    endcase
    is_byte = is_add || is_and;
  end

  // The file read is combinational, so the addressed operand is ready this cycle
  assign file_rd_addr = faddr;

  // ---------------------------------------------------------------
  // Operand select
  // ---------------------------------------------------------------
  // Port reads sample the pins so a driven-low input is written back low
  assign operand = file_is_port ? port_pins : file_rd_data;

  // ---------------------------------------------------------------
  // Arithmetic and logic
  // ---------------------------------------------------------------
  fraops_adder u_adder (
    .a          (st.acc),
    .b          (operand),
    .sum        (sum),
    .carry      (sum_c),
    .half_carry (sum_dc)
  );

  assign and_val = st.acc & operand;

  // A decoded mask rather than a shift keeps the clear to exactly one bit
  always_comb begin
    case (bit_idx)
      3'h0:    bit_mask = 8'hFE;
      3'h1:    bit_mask = 8'hFD;
      3'h2:    bit_mask = 8'hFB;
      3'h3:    bit_mask = 8'hF7;
      3'h4:    bit_mask = 8'hEF;
      3'h5:    bit_mask = 8'hDF;
      3'h6:    bit_mask = 8'hBF;
      3'h7:    bit_mask = 8'h7F;
      default: bit_mask = 8'hFF;
    endcase
  end

  assign clr_val = operand & bit_mask;

  // ---------------------------------------------------------------
  // Result and zero detect
  // ---------------------------------------------------------------
  always_comb begin
    if (is_add) begin
      result = sum;
    end else begin
      result = and_val;
    end
    result_zero = (result == 8'h00);
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Only the add touches carry and half-carry; a bit clear touches no flag
  always_comb begin
    new_flags = st.flags;
    if (is_add) begin
      new_flags.c  = sum_c;
      new_flags.dc = sum_dc;
      new_flags.z  = result_zero;
    end else if (is_and) begin
      new_flags.z = result_zero;
    end
  end

  // ---------------------------------------------------------------
  // Destination and side effects
  // ---------------------------------------------------------------
  // Byte ops steer by the destination bit; a bit clear always writes back
  assign to_acc  = is_byte && !dest;
  assign to_file = (is_byte && dest) || is_bclr;

  // Every write-back to the timer count register restarts an assigned prescaler
  assign hits_timer = to_file && file_is_timer && prescaler_on_timer;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.flags  = new_flags;
    next_st.fwr.we = 1'h0;
    next_st.pclr   = hits_timer;
    if (to_acc) begin
      next_st.acc = result;
    end
    if (to_file) begin
      next_st.fwr.we   = 1'h1;
      next_st.fwr.addr = faddr;
      next_st.fwr.data = is_bclr ? clr_val : result;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Address and data of the write port hold between pulses; only the strobe drops
  always_ff @(posedge mclk) begin
    if (rst) begin
      st.acc      <= `FRAOPS_ACC_RST;
      st.flags    <= `FRAOPS_FLAGS_RST;
      st.fwr.we   <= 1'h0;
      st.fwr.addr <= `FRAOPS_ADDR_RST;
      st.fwr.data <= 8'h00;
      st.pclr     <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // A write-back lands one cycle after the instruction; the core does not forward,
  // so the next instruction must not read the same file register
  assign file_wr       = st.fwr;
  assign acc           = st.acc;
  assign flags         = st.flags;
  assign prescaler_clr = st.pclr;
endmodule : fraops_core

// ===== fraops_core_props.sv
// Checker for the file-register ALU slice
module fraops_core_props (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      file_is_port,
  input wire logic                      file_is_timer,
  input wire logic                      prescaler_on_timer,
  input wire logic                      prescaler_clr,
  input wire logic [7:0]                file_rd_data,
  input wire logic [7:0]                port_pins,
  input wire logic [7:0]                acc,
  input wire fraops_pkg::fraops_instr_t instr,
  input wire fraops_pkg::fraops_fwr_t   file_wr,
  input wire fraops_pkg::fraops_flags_t flags
);
  timeunit 1ns;
  timeprecision 1ps;
  import fraops_pkg::*;
  // Port reads take the pin levels
  wire [7:0] o = file_is_port ? port_pins : file_rd_data;
  wire [8:0] s = acc + o;
  wire [2:0] fa = {s[8], acc[3:0] + o[3:0] > 5'h0F, s[7:0] == 8'h00};
  wire [7:0] r = instr.word[9] ? s[7:0] : acc & o;
  wire ad = instr.valid && instr.word[13:8] == 6'h07;
  wire by = ad || instr.valid && instr.word[13:8] == 6'h05;
  wire bc = instr.valid && instr.word[13:10] == 4'h4;
  wire wb = by && instr.word[7] || bc;
  wire [15:0] fw = {1'h1, instr.word[6:0], bc ? o & ~(8'h01 << instr.word[9:7]) : r};
  wire pz = wb && file_is_timer && prescaler_on_timer;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_add_flags: assert property (ad |=> flags == $past(fa)) else $error("add flags");
  a_and_zero: assert property (by && !ad |=> flags == {$past(flags[2:1]), $past(r) == 8'h00}) else $error("and");
  a_acc_dest: assert property (by && !wb |=> acc == $past(r) && !file_wr.we) else $error("acc");
  a_file_dest: assert property (wb |=> file_wr == $past(fw) && $stable(acc)) else $error("file");
  a_clr_quiet: assert property (bc |=> $stable(flags)) else $error("clear flags");
  a_presc_clr: assert property (pz |=> prescaler_clr) else $error("prescaler");
  a_presc_idle: assert property (!pz |=> !prescaler_clr) else $error("prescaler idle");
endmodule : fraops_core_props
bind fraops_core fraops_core_props fraops_core_props_inst (
  .mclk               (mclk),
  .rst                (rst),
  .file_is_port       (file_is_port),
  .file_is_timer      (file_is_timer),
  .prescaler_on_timer (prescaler_on_timer),
  .prescaler_clr      (prescaler_clr),
  .file_rd_data       (file_rd_data),
  .port_pins          (port_pins),
  .acc                (acc),
  .instr              (instr),
  .file_wr            (file_wr),
  .flags              (flags)
);

// ===== fraops_defines.svh
// Opcode fields, flag positions and reset values for the file-register ALU slice
`ifndef FRAOPS_DEFINES_SVH
`define FRAOPS_DEFINES_SVH
`define FRAOPS_OP_ADD      4'h7
`define FRAOPS_OP_AND      4'h5
`define FRAOPS_CLS_BYTE    2'h0
`define FRAOPS_CLS_BIT     2'h1
`define FRAOPS_BOP_CLR     2'h0
`define FRAOPS_FLAG_C      0
`define FRAOPS_FLAG_DC     1
`define FRAOPS_FLAG_Z      2
`define FRAOPS_ACC_RST     8'h00
`define FRAOPS_FLAGS_RST   3'h0
`define FRAOPS_ADDR_RST    7'h00
`endif

// ===== fraops_file_model.sv
// File register array beside the ALU slice
module fraops_file_model (
  input  wire logic                    mclk,
  input  wire logic [6:0]              file_rd_addr,
  input  wire fraops_pkg::fraops_fwr_t file_wr,
  output logic [7:0]                   file_rd_data
);
  timeunit 1ns / 1ps;
  import fraops_pkg::*;
  logic [7:0] mem [128];
  // Known contents, zero elsewhere, so a wrong address shows up as a wrong value
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'h00;
    end
    mem[16] = 8'h17;
    mem[17] = 8'hC2;
    mem[18] = 8'h00;
    mem[19] = 8'hF9;
    mem[20] = 8'h20;
    mem[21] = 8'hC7;
    mem[22] = 8'h0F;
    mem[23] = 8'h01;
  end
  // Read is combinational: the slice takes its operand in the same cycle
  assign file_rd_data = mem[file_rd_addr];
  always @(posedge mclk) begin
    if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
  end
endmodule : fraops_file_model

// ===== fraops_pkg.sv
// Types shared by the file-register ALU slice
package fraops_pkg;
  typedef struct packed {
    logic        valid;
    logic [13:0] word;
  } fraops_instr_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } fraops_fwr_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } fraops_flags_t;
endpackage : fraops_pkg

// ===== testbench.sv
// Self-checking bench for the file-register ALU slice
module testbench;
  timeunit 1ns / 1ps;
  import fraops_pkg::*;
  logic mclk = 1'h0, rst = 1'h1, file_is_port = 1'h0, file_is_timer = 1'h0, prescaler_on_timer = 1'h0, prescaler_clr;
  logic [7:0] port_pins = 8'hF0, file_rd_data, acc;
  logic [6:0] file_rd_addr;
  fraops_instr_t instr = '0;
  fraops_fwr_t file_wr;
  fraops_flags_t flags;
  int fail_count = 0, total_checks = 0;
  wire [31:0] got = {acc, 4'h0, prescaler_clr, flags, file_wr};
  fraops_core fraops_core_inst (
    .mclk               (mclk),
    .rst                (rst),
    .instr              (instr),
    .file_rd_data       (file_rd_data),
    .file_is_port       (file_is_port),
    .port_pins          (port_pins),
    .file_is_timer      (file_is_timer),
    .prescaler_on_timer (prescaler_on_timer),
    .file_rd_addr       (file_rd_addr),
    .file_wr            (file_wr),
    .acc                (acc),
    .flags              (flags),
    .prescaler_clr      (prescaler_clr)
  );
  fraops_file_model fraops_file_model_inst (
    .mclk         (mclk),
    .file_rd_addr (file_rd_addr),
    .file_wr      (file_wr),
    .file_rd_data (file_rd_data)
  );
  initial forever #20 mclk = ~mclk;
  // One instruction, then an idle cycle so the write lands before the next read
  task automatic ex(input logic [16:0] w, input logic [31:0] e);
    @(posedge mclk) {file_is_port, file_is_timer, prescaler_on_timer, instr} <= {w[16:14], 1'h1, w[13:0]};
    @(posedge mclk) instr <= '0;
    #1 total_checks++;
    if (got !== e) begin
      $display("MISMATCH %0t %h %h", $time, got, e);
      fail_count++;
    end
  endtask : ex
  task automatic t_byte;
    ex(17'h00710, 32'h17000000);
    ex(17'h00791, 32'h170091D9);
    ex(17'h00713, 32'h100611D9);
    ex(17'h00591, 32'h10069110);
    ex(17'h00514, 32'h00071110);
  endtask : t_byte
  task automatic t_bit;
    ex(17'h01395, 32'h00079547);
    ex(17'h11216, 32'h000796E0);
    ex(17'h0C797, 32'h00089701);
    ex(17'h0C717, 32'h01001701);
    ex(17'h0D795, 32'h01001701);
  endtask : t_bit
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    t_byte();
    t_bit();
    test_done();
  end
endmodule : testbench
